// file: test_temp_sensor_serial_readout.sv
// Self-checking bench for the sensor serial readout with a host model.
// Assumes short conversion and write counts passed as parameters.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module test_temp_sensor_serial_readout;
  // ==========================================================================
  // Signals
  localparam int unsigned CONV = 20;  // Short nine-bit conversion
  localparam int unsigned NV = 10;    // Short limit write time
  logic i_core_clk, i_sys_rst, i_clk_en, i_port_type_strap;
  logic i_ce, i_sclk, i_sdi;
  logic [11:0] i_adc_data;
  logic o_sdo, o_sdo_oe, o_thermostat_alarm_out, o_thermostat_alarm_oe, o_nv_busy;
  int n_errors, n_tests, nb_cnt;
  logic [8:0] exp_q[$];  // Expected frame results, oldest first
  logic [8:0] exp_n;     // Note taken off the queue, popped once per frame
  logic [11:0] a;
  logic [15:0] t;

  tssr_top #(.CONV_BASE_CYC(CONV), .NV_WR_CYC(NV)) uut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_port_type_strap(i_port_type_strap), .i_ce(i_ce), .i_sclk(i_sclk),
    .i_sdi(i_sdi), .i_adc_data(i_adc_data), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_thermostat_alarm_out(o_thermostat_alarm_out),
    .o_thermostat_alarm_oe(o_thermostat_alarm_oe), .o_nv_busy(o_nv_busy));

  tssr_host_model host (
    .i_strap_spi(i_port_type_strap), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe),
    .o_ce(i_ce), .o_sclk(i_sclk), .o_sdi(i_sdi));

  // Core clock, 100 MHz
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Counts cycles with a limit write in flight
  always @(posedge i_core_clk) begin
    if (o_nv_busy === 1'b1) nb_cnt++;
  end

  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic do_reset(input logic spi);
    tick(1);
    i_port_type_strap = spi;
    i_sys_rst = 1'b1;
    tick(3);
    i_sys_rst = 1'b0;
    tick(10);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back({1'b1, exp});
    host.xfer(addr, 8'h00);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    exp_q.push_back(9'h100);
    host.xfer(addr, data);
  endtask

  // Adc input changes just after a core edge
  task automatic setadc(input logic [11:0] v);
    tick(1);
    i_adc_data = v;
  endtask

  // Stored value: low nibble zero, bits below the resolution cleared
  function automatic logic [15:0] tmp(input logic [11:0] v, input int r);
    return {v, 4'h0} & ~(16'h007F >> r);
  endfunction

  task automatic print_verdict();
    if (exp_q.size() != 0) n_errors++;
    $display("Checks made %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Result watcher: each finished frame takes the oldest note
  initial begin
    forever begin
      @(host.done_e);
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("CHECK FAILED at %0t: unexpected frame", $time);
      end else begin
        exp_n = exp_q.pop_front();
        `CHK(host.res_q, exp_n)
      end
    end
  end

  // Watchdog, well beyond the planned run
  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    n_errors = 0;
    n_tests = 0;
    nb_cnt = 0;
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_port_type_strap = 1'b1;
    i_adc_data = 12'h000;
    void'($urandom(32'h2833));
    do_reset(1'b1);
    // Power-up state over the SPI port
    rd(8'h00, 8'h01);
    rd(8'h04, 8'h50);
    rd(8'h06, 8'h4B);
    tick(100);
    rd(8'h02, 8'h00);
    $display("test power_up done");
    // One-shot at every resolution, random temperatures
    for (int r = 0; r < 4; r++) begin
      a = 12'($urandom());
      setadc(a);
      wr(8'h80, 8'h11 | 8'(r << 2));
      tick((CONV << r) + 30);
      t = tmp(a, r);
      rd(8'h00, 8'h01 | 8'(r << 2));
      rd(8'h01, t[7:0]);
      rd(8'h02, t[15:8]);
    end
    $display("test one_shot done");
    // Continuous at twelve bits; reads must not hold conversions back
    a = {8'($urandom()), 4'h0};
    setadc(a);
    wr(8'h80, 8'h0C);
    tick((CONV << 3) + 40);
    rd(8'h02, a[11:4]);
    a = {8'($urandom()), 4'h0};
    setadc(a);
    repeat (6) rd(8'h01, 8'h00);
    rd(8'h02, a[11:4]);
    $display("test continuous done");
    // Three-wire port, limit write timing, interrupt alarm
    do_reset(1'b0);
    rd(8'h00, 8'h01);
    nb_cnt = 0;
    wr(8'h84, 8'h30);
    tick(NV + 20);
    `CHK(nb_cnt >= 1 && nb_cnt <= NV + 1, 1'b1)
    rd(8'h04, 8'h30);
    setadc(12'h400);
    wr(8'h80, 8'h13);
    tick(CONV + 30);
    `CHK(o_thermostat_alarm_oe, 1'b1)
    `CHK(o_thermostat_alarm_out, 1'b0)
    rd(8'h00, 8'h03);
    tick(10);
    `CHK(o_thermostat_alarm_oe, 1'b0)
    $display("test three_wire done");
    // Clock enable low freezes the core; the link still answers from held state
    tick(1);
    i_clk_en = 1'b0;
    wr(8'h80, 8'h0C);
    tick(5);
    rd(8'h00, 8'h03);
    tick(1);
    i_clk_en = 1'b1;
    tick(5);
    rd(8'h00, 8'h0C);
    $display("test clock_enable done");
    tick(10);
    print_verdict();
  end
endmodule

// file: tssr_host_model.sv
// Behavioural host master that runs frames on the sensor's serial port.
// Assumes the bench calls xfer one frame at a time and reads res_q at done_e.
`timescale 1ns/10ps
module tssr_host_model (
  input wire logic i_strap_spi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_ce,
  output logic o_sclk,
  output wire logic o_sdi
);
  // ==========================================================================
  // Line state
  logic drv_q;        // Host drives the data line
  logic bit_q;        // Bit the host is sending
  logic idle_q;       // Changing level on a released line, never a stale bit
  logic [8:0] res_q;  // Frame result: enable pattern ok, then read byte
  event done_e;       // Fires once per finished frame

  assign o_sdi = (!i_strap_spi && i_sdo_oe) ? i_sdo : (drv_q ? bit_q : idle_q);

  // Link clock stands still outside frames
  initial begin
    o_ce = 1'b0;
    o_sclk = 1'b0;
    drv_q = 1'b0;
    bit_q = 1'b0;
    idle_q = 1'b0;
    res_q = 9'h000;
  end

  // ==========================================================================
  // One frame: address byte then data byte, 30 ns link clock
  // frame and bit order
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata);
    logic rd;
    logic ok;
    logic [7:0] got;
    int p;
    rd = !addr[7];
    ok = 1'b1;
    got = 8'h00;
    o_ce = 1'b1;
    #45;
    for (int i = 0; i < 16; i++) begin
      p = i_strap_spi ? 7 - (i % 8) : i % 8;
      drv_q = !(rd && i >= 8);
      bit_q = (i < 8) ? addr[p] : wdata[p];
      idle_q = ~idle_q;
      #15;
      o_sclk = 1'b1;
      // Device may drive only during the returned byte
      ok &= (i_sdo_oe === (rd && i >= 8));
      if (rd && i >= 8) begin
        // A released SPI output reads as the inverse of its last bit; the three-wire line reads the changing idle level
        got[p] = i_strap_spi ? (i_sdo_oe ? i_sdo : ~i_sdo) : o_sdi;
      end
      #15;
      o_sclk = 1'b0;
    end
    #15;
    ok &= (i_sdo_oe === 1'b0);
    o_ce = 1'b0;
    drv_q = 1'b0;
    res_q = {ok, got};
    -> done_e;
    // gap lets events cross and writes settle
    #60;
  endtask
endmodule

// file: tssr_pkg.sv
// Constants, types and encodings for the temperature sensor serial readout.
// Assumes a 100 MHz core clock and a host-made serial clock that runs only inside frames.
// ============================================================================
// Summary of operation
// - Strap high selects SPI, low three-wire
// - Three-wire shares data line; drive only reads
// - Shift data on host serial clock edges
// - Continuous mode converts and stores repeatedly
// - Register reads never disturb running conversion
// - One-shot converts once, then shuts down
// - Resolution defaults nine bits, writable to twelve
// - Alarm output trips on high/low limits
// - Nonvolatile write finishes within fifteen milliseconds
// - Configuration write picks continuous or one-shot
// - Power up in shutdown, no conversions
// - SPI sends MSB first, three-wire LSB first
// - Temperature register loads only while deselected
// - Any read clears interrupt-mode alarm
package tssr_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CORE_CLK_HZ = 100_000_000; // Core clock rate
  localparam int unsigned CONV_9B_MS = 25;           // Nine-bit conversion time, ms
  localparam int unsigned NV_WR_MS = 15;             // Longest nonvolatile write, ms
  localparam int unsigned CONV_9B_CYC = CONV_9B_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned NV_WR_CYC = NV_WR_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned CNT_W = 25;                // Holds the twelve-bit time

  // ==========================================================================
  // Serial frame: eight address bits, then eight data bits
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
  localparam logic [4:0] BIT_DATA_LAST = 5'h0F;
  localparam logic [4:0] BIT_FRAME_END = 5'h10;
  localparam int unsigned ADDR_WR_BIT = 7;           // Set in a write address

  // ==========================================================================
  // Register addresses (write address adds the write bit)
  localparam logic [6:0] ADDR_CFG = 7'h00;
  localparam logic [6:0] ADDR_TEMP_LSB = 7'h01;
  localparam logic [6:0] ADDR_TEMP_MSB = 7'h02;
  localparam logic [6:0] ADDR_THI_LSB = 7'h03;
  localparam logic [6:0] ADDR_THI_MSB = 7'h04;
  localparam logic [6:0] ADDR_TLO_LSB = 7'h05;
  localparam logic [6:0] ADDR_TLO_MSB = 7'h06;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] CFG_RST = 8'h01;        // Shutdown, comparator, nine bits
  localparam logic [15:0] THI_RST = 16'h5000;    // Factory high limit
  localparam logic [15:0] TLO_RST = 16'h4B00;    // Factory low limit
  localparam logic [15:0] RES_MASK_9B = 16'hFF80; // Kept bits at nine-bit resolution
  localparam logic [3:0] TEMP_PAD = 4'h0;        // Unused low nibble

  // Configuration/status byte
  typedef struct packed {
    logic nv_busy;     // Status: nonvolatile write running
    logic [1:0] rsvd;  // Read as zero
    logic one_shot;    // Request one conversion
    logic [1:0] res;   // 0..3 = 9..12 bits
    logic int_mode;    // Thermostat interrupt mode
    logic shutdown;    // No continuous conversions
  } tssr_cfg_t;

  // Write command handed from the link to the core
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } tssr_wr_t;

  // Conversion sequencer
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN = 2'b10
  } tssr_conv_t;

endpackage

// file: tssr_top.sv
// Serial register port, conversion sequencer and thermostat of the sensor.
// Assumes i_sclk ticks only while i_ce is high and i_adc_data is on the core clock.
`timescale 1ns/10ps
module tssr_top #(
  parameter int unsigned CONV_BASE_CYC = tssr_pkg::CONV_9B_CYC, // Nine-bit conversion
  parameter int unsigned NV_WR_CYC = tssr_pkg::NV_WR_CYC         // Nonvolatile write
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_port_type_strap,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic [11:0] i_adc_data,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_thermostat_alarm_out,
  output logic o_thermostat_alarm_oe,
  output logic o_nv_busy
);

  // ==========================================================================
  // Declarations
  logic [4:0] bit_cnt_q;              // Serial bits seen this frame
  logic [7:0] rx_sh_q;                // Incoming shift register
  logic [7:0] rx_next;                // Shift register after this bit
  logic [7:0] addr_q;                 // Address byte of this frame
  logic [7:0] tx_sh_q;                // Outgoing read data
  logic [7:0] rd_byte;                // Addressed register contents
  logic rd_tgl_q;                     // Flips per read address
  logic wr_tgl_q;                     // Flips per write byte
  tssr_pkg::tssr_wr_t wr_cmd_q;       // Held until the next write
  logic sdo_q;
  logic sdo_oe_q;
  logic [2:0] sync_s1_q;              // First stage: ce, read, write
  logic [2:0] sync_s2_q;
  logic [1:0] tgl_s3_q;               // Previous toggle values
  logic strap_s1_q;
  logic strap_s2_q;
  logic strap_done_q;
  logic mode_spi_q;                   // Latched port type
  logic ce_s2;
  logic rd_evt;
  logic wr_evt;
  tssr_pkg::tssr_cfg_t cfg_q;
  tssr_pkg::tssr_conv_t cst_q;
  logic [tssr_pkg::CNT_W-1:0] conv_cnt_q;
  logic [tssr_pkg::CNT_W-1:0] conv_len;
  logic conv_done;
  logic [15:0] res_mask;
  logic [15:0] pend_q;                // Result waiting for a quiet port
  logic pend_v_q;
  logic [15:0] temp_q;
  logic load_evt;
  logic [15:0] thi_q;
  logic [15:0] tlo_q;
  logic hi_trip;
  logic lo_trip;
  logic alarm_q;
  logic want_low_q;                   // Interrupt mode waits for low limit
  logic alarm_set;
  logic alarm_clr;
  logic nv_busy_q;
  logic [tssr_pkg::CNT_W-1:0] nv_cnt_q;
  tssr_pkg::tssr_wr_t nv_cmd_q;       // Limit byte being committed
  logic cfg_wr;

  // ==========================================================================
  // Link domain: receive side
  // bit order
  assign rx_next = mode_spi_q ? {rx_sh_q[6:0], i_sdi} : {i_sdi, rx_sh_q[7:1]};

  // Chip select low clears the frame; the clock stops between frames
  // frame gating
  always_ff @(posedge i_sclk or negedge i_ce) begin
    if (!i_ce) begin
      bit_cnt_q <= '0;
      rx_sh_q <= '0;
      addr_q <= '0;
    end else begin
      if (bit_cnt_q != tssr_pkg::BIT_FRAME_END) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      rx_sh_q <= rx_next;
      if (bit_cnt_q == tssr_pkg::BIT_ADDR_LAST) begin
        addr_q <= rx_next;
      end
    end
  end

  // Events for the core; held words stay put until the next write frame
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_tgl_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      wr_cmd_q <= '0;
    end else begin
      // Read address seen
      if (bit_cnt_q == tssr_pkg::BIT_ADDR_LAST && !rx_next[tssr_pkg::ADDR_WR_BIT]) begin
        rd_tgl_q <= ~rd_tgl_q;
      end
      // Write byte complete
      if (bit_cnt_q == tssr_pkg::BIT_DATA_LAST && addr_q[tssr_pkg::ADDR_WR_BIT]) begin
        wr_cmd_q <= '{addr: addr_q[6:0], data: rx_next};
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // Core registers are read across domains; only the temperature waits for chip select low,
  // so it stands still from the address byte onward; configuration and limits can move at any time
  always_comb begin
    rd_byte = 8'h00;
    if (addr_q[6:0] == tssr_pkg::ADDR_CFG) begin
      rd_byte = {nv_busy_q, cfg_q[6:0]};
    end else if (addr_q[6:0] == tssr_pkg::ADDR_TEMP_LSB) begin
      rd_byte = temp_q[7:0];
    end else if (addr_q[6:0] == tssr_pkg::ADDR_TEMP_MSB) begin
      rd_byte = temp_q[15:8];
    end else if (addr_q[6:0] == tssr_pkg::ADDR_THI_LSB) begin
      rd_byte = thi_q[7:0];
    end else if (addr_q[6:0] == tssr_pkg::ADDR_THI_MSB) begin
      rd_byte = thi_q[15:8];
    end else if (addr_q[6:0] == tssr_pkg::ADDR_TLO_LSB) begin
      rd_byte = tlo_q[7:0];
    end else if (addr_q[6:0] == tssr_pkg::ADDR_TLO_MSB) begin
      rd_byte = tlo_q[15:8];
    end
  end

  // ==========================================================================
  // Link domain: transmit side, changes on falling edges
  always_ff @(negedge i_sclk or negedge i_ce) begin
    if (!i_ce) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      tx_sh_q <= '0;
    end else if (bit_cnt_q == tssr_pkg::BIT_DATA_FIRST && !addr_q[tssr_pkg::ADDR_WR_BIT]) begin
      sdo_oe_q <= 1'b1;
      sdo_q <= mode_spi_q ? rd_byte[7] : rd_byte[0];
      tx_sh_q <= mode_spi_q ? {rd_byte[6:0], 1'b0} : {1'b0, rd_byte[7:1]};
    end else if (bit_cnt_q > tssr_pkg::BIT_DATA_FIRST && bit_cnt_q <= tssr_pkg::BIT_DATA_LAST) begin
      sdo_q <= mode_spi_q ? tx_sh_q[7] : tx_sh_q[0];
      tx_sh_q <= mode_spi_q ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
    end else begin
      sdo_oe_q <= 1'b0;
    end
  end

  assign o_sdo = sdo_q;
  assign o_sdo_oe = sdo_oe_q;

  // ==========================================================================
  // Core domain: synchronisers and strap capture
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sync_s1_q <= '0;
      sync_s2_q <= '0;
      tgl_s3_q <= '0;
    end else if (i_clk_en) begin
      sync_s1_q <= {wr_tgl_q, rd_tgl_q, i_ce};
      sync_s2_q <= sync_s1_q;
      tgl_s3_q <= sync_s2_q[2:1];
    end
  end

  // Strap synchroniser keeps running through reset, so the latch below sees the
  // pin level at the first edge after release and not a cleared stage
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_clk_en) begin
      strap_s1_q <= i_port_type_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  assign ce_s2 = sync_s2_q[0];
  assign rd_evt = sync_s2_q[1] ^ tgl_s3_q[0];
  assign wr_evt = sync_s2_q[2] ^ tgl_s3_q[1];

  // Strap is taken once after reset release, past the synchroniser
  // port type latch
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      strap_done_q <= 1'b0;
      mode_spi_q <= 1'b0;
    end else if (i_clk_en && !strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_spi_q <= strap_s2_q;
    end
  end

  // ==========================================================================
  // Configuration register, written at once; one-shot clears itself
  assign cfg_wr = wr_evt && wr_cmd_q.addr == tssr_pkg::ADDR_CFG;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cfg_q <= tssr_pkg::CFG_RST;
    end else if (i_clk_en) begin
      if (cfg_wr) begin
        cfg_q <= {1'b0, 2'b00, wr_cmd_q.data[4:0]};
      end else if (conv_done) begin
        cfg_q.one_shot <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Conversion sequencer
  // time doubles per bit
  assign conv_len = tssr_pkg::CNT_W'(CONV_BASE_CYC) << cfg_q.res;
  assign conv_done = cst_q == tssr_pkg::CONV_RUN && conv_cnt_q == conv_len - 1'b1;
  assign res_mask = 16'($signed(tssr_pkg::RES_MASK_9B) >>> cfg_q.res);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cst_q <= tssr_pkg::CONV_IDLE;
      conv_cnt_q <= '0;
    end else if (i_clk_en) begin
      case (cst_q)
        tssr_pkg::CONV_IDLE: begin
          conv_cnt_q <= '0;
          if (!cfg_q.shutdown || cfg_q.one_shot) begin
            cst_q <= tssr_pkg::CONV_RUN;
          end
        end
        tssr_pkg::CONV_RUN: begin
          if (conv_done) begin
            conv_cnt_q <= '0;
            if (cfg_q.shutdown) begin
              cst_q <= tssr_pkg::CONV_IDLE;
            end
          end else begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
          end
        end
        default: begin
          cst_q <= tssr_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // Result waits while the port is active, so a read never sees a torn value
  assign load_evt = pend_v_q && !ce_s2;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pend_q <= '0;
      pend_v_q <= 1'b0;
      temp_q <= '0;
    end else if (i_clk_en) begin
      if (load_evt) begin
        temp_q <= pend_q;
        pend_v_q <= 1'b0;
      end
      // A new result wins over the load that empties the slot
      if (conv_done) begin
        pend_q <= {i_adc_data, tssr_pkg::TEMP_PAD} & res_mask;
        pend_v_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Limit registers with nonvolatile write timing
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      thi_q <= tssr_pkg::THI_RST;
      tlo_q <= tssr_pkg::TLO_RST;
      nv_busy_q <= 1'b0;
      nv_cnt_q <= '0;
      nv_cmd_q <= '0;
    end else if (i_clk_en) begin
      if (nv_busy_q) begin
        if (nv_cnt_q == tssr_pkg::CNT_W'(NV_WR_CYC - 1)) begin
          nv_busy_q <= 1'b0;
          if (nv_cmd_q.addr == tssr_pkg::ADDR_THI_LSB) thi_q[7:0] <= nv_cmd_q.data;
          if (nv_cmd_q.addr == tssr_pkg::ADDR_THI_MSB) thi_q[15:8] <= nv_cmd_q.data;
          if (nv_cmd_q.addr == tssr_pkg::ADDR_TLO_LSB) tlo_q[7:0] <= nv_cmd_q.data;
          if (nv_cmd_q.addr == tssr_pkg::ADDR_TLO_MSB) tlo_q[15:8] <= nv_cmd_q.data;
        end else begin
          nv_cnt_q <= nv_cnt_q + 1'b1;
        end
      end else if (wr_evt && wr_cmd_q.addr >= tssr_pkg::ADDR_THI_LSB
                   && wr_cmd_q.addr <= tssr_pkg::ADDR_TLO_MSB) begin
        nv_busy_q <= 1'b1;
        nv_cnt_q <= '0;
        nv_cmd_q <= wr_cmd_q;
      end
    end
  end

  assign o_nv_busy = nv_busy_q;

  // ==========================================================================
  // Thermostat, compared at the resolution in use
  assign hi_trip = $signed(pend_q) > $signed(thi_q & res_mask);
  assign lo_trip = $signed(pend_q) < $signed(tlo_q & res_mask);
  assign alarm_set = load_evt && !alarm_q && (want_low_q ? lo_trip : hi_trip);
  assign alarm_clr = rd_evt || (cfg_wr && wr_cmd_q.data[0] && !wr_cmd_q.data[4]);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      alarm_q <= 1'b0;
      want_low_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!cfg_q.int_mode) begin
        want_low_q <= 1'b0;
        if (load_evt && hi_trip) alarm_q <= 1'b1;
        else if (load_evt && lo_trip) alarm_q <= 1'b0;
      end else if (alarm_set) begin
        alarm_q <= 1'b1;
        want_low_q <= ~want_low_q;
      end else if (alarm_clr) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // Open drain: pulls low while the alarm is active
  assign o_thermostat_alarm_out = 1'b0;
  assign o_thermostat_alarm_oe = alarm_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_conv_end;
    conv_done && i_clk_en;
  endsequence

  strap_latch_a: assert property ($rose(strap_done_q) |-> mode_spi_q == $past(strap_s2_q))
    else $error("port type not taken from strap");
  sdo_quiet_a: assert property (!i_ce |-> !o_sdo_oe)
    else $error("data output driven while deselected");
  cont_loop_a: assert property (s_conv_end ##0 !cfg_q.shutdown |=> cst_q == tssr_pkg::CONV_RUN && conv_cnt_q == '0)
    else $error("continuous conversion did not restart");
  read_no_disturb_a: assert property (rd_evt && cst_q == tssr_pkg::CONV_RUN && !conv_done && i_clk_en
    |=> cst_q == tssr_pkg::CONV_RUN && conv_cnt_q == $past(conv_cnt_q) + 1'b1)
    else $error("read disturbed conversion");
  oneshot_back_a: assert property (s_conv_end ##0 cfg_q.shutdown && !cfg_wr
    |=> cst_q == tssr_pkg::CONV_IDLE && !cfg_q.one_shot)
    else $error("one-shot did not return to shutdown");
  res_default_a: assert property ($fell(i_sys_rst) |-> cfg_q.res == 2'b00 && cfg_q.shutdown
    && cst_q == tssr_pkg::CONV_IDLE)
    else $error("reset state not nine-bit shutdown");
  temp_hold_a: assert property (ce_s2 |=> $stable(temp_q))
    else $error("temperature changed during access");
  nv_bound_a: assert property (nv_busy_q |-> nv_cnt_q < tssr_pkg::CNT_W'(NV_WR_CYC))
    else $error("nonvolatile write overran");
  alarm_read_a: assert property (rd_evt && cfg_q.int_mode && !alarm_set && i_clk_en |=> !o_thermostat_alarm_oe)
    else $error("read did not clear alarm");
  alarm_trip_a: assert property (load_evt && hi_trip && !cfg_q.int_mode && i_clk_en |=> o_thermostat_alarm_oe)
    else $error("alarm missed high limit");

endmodule
